// [src/rtcacp_pkg.sv]
// Constants for the clock alarm compare and interrupt control block.
// Assumes a 125 MHz system clock and count-source and 256 Hz enable pulses from the prescaler.
package rtcacp_pkg;

    // ==========================================================
    // Register indices; byte address is four times the index
    // ==========================================================
    localparam logic [31:0] IDX_WEEKDAY_ALARM   = 32'h0008c416;
    localparam logic [31:0] IDX_DATE_ALARM      = 32'h0008c418;
    localparam logic [31:0] IDX_MONTH_ALARM     = 32'h0008c41a;
    localparam logic [31:0] IDX_YEAR_ALARM      = 32'h0008c41c;
    localparam logic [31:0] IDX_YEAR_ALARM_EN   = 32'h0008c41e;
    localparam logic [31:0] IDX_IRQ_OUT_CTRL    = 32'h0008c422;
    localparam logic [31:0] IDX_COUNT_CTRL      = 32'h0008c424;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CMP_EN_BIT        = 7;
    localparam int AIE_BIT           = 0;
    localparam int CIE_BIT           = 1;
    localparam int PIE_BIT           = 2;
    localparam int RATE_SEL_BIT      = 3;
    localparam int PES_LSB           = 4;
    localparam int CC_START_BIT      = 0;
    localparam int CC_SWRST_BIT      = 1;
    localparam int CC_OUT_EN_BIT     = 3;
    localparam int CC_MODE_BIT       = 7;
    localparam int OUT_1HZ_BIT       = 7;
    localparam int OUT_64HZ_BIT      = 1;

    // ==========================================================
    // Reset values and codes
    // ==========================================================
    localparam logic [7:0]  ALARM_RST        = 8'h00;
    localparam logic [7:0]  CTRL_RST         = 8'h00;
    localparam logic [2:0]  WEEKDAY_BANNED   = 3'h7;
    localparam logic [8:0]  DIV_RST          = 9'h000;

    typedef enum logic [3:0] {
        RTCACP_PES_256 = 4'b0110,
        RTCACP_PES_128 = 4'b0111,
        RTCACP_PES_64  = 4'b1000,
        RTCACP_PES_32  = 4'b1001,
        RTCACP_PES_16  = 4'b1010,
        RTCACP_PES_8   = 4'b1011,
        RTCACP_PES_4   = 4'b1100,
        RTCACP_PES_2   = 4'b1101,
        RTCACP_PES_1S  = 4'b1110,
        RTCACP_PES_2S  = 4'b1111
    } rtcacp_pes_t;

endpackage : rtcacp_pkg

// [src/rtcacp_top.sv]
// Alarm compare, interrupt enables, periodic interrupt and clock output control.
// Assumes the counters live outside and present their values and tick pulses here.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ns
module rtcacp_top
    import rtcacp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [31:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        count_tick,
    input  wire logic        tick_256hz,
    input  wire logic        carry_event,
    input  wire logic [2:0]  weekday_counter,
    input  wire logic [5:0]  date_counter,
    input  wire logic [4:0]  month_counter,
    input  wire logic [7:0]  year_counter,
    input  wire logic [31:0] binary_counter_value,
    input  wire logic [23:0] bin_alarm_low,
    input  wire logic        alarm_ack,
    input  wire logic        periodic_ack,
    input  wire logic        carry_ack,
    output logic             alarm_irq,
    output logic             periodic_irq,
    output logic             carry_irq,
    output logic             clock_out_pin,
    output logic             count_run,
    output logic             count_mode_select
);
    import rtcacp_pkg::*;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Returns {valid, mask}; period hits when the low masked divider bits wrap to zero
    function automatic logic [9:0] pes_mask(input logic [3:0] code);
        logic [9:0] r;
        r = 10'h000;
        case (code)
            RTCACP_PES_256: r = 10'h200;
            RTCACP_PES_128: r = 10'h201;
            RTCACP_PES_64:  r = 10'h203;
            RTCACP_PES_32:  r = 10'h207;
            RTCACP_PES_16:  r = 10'h20f;
            RTCACP_PES_8:   r = 10'h21f;
            RTCACP_PES_4:   r = 10'h23f;
            RTCACP_PES_2:   r = 10'h27f;
            RTCACP_PES_1S:  r = 10'h2ff;
            RTCACP_PES_2S:  r = 10'h3ff;
            default:        r = 10'h000;
        endcase
        return r;
    endfunction : pes_mask

    function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
        return a == {idx[29:0], 2'b00};
    endfunction : hit

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0]  weekday_alarm_ff;
    logic [7:0]  date_alarm_ff;
    logic [7:0]  month_alarm_ff;
    logic [7:0]  year_alarm_ff;
    logic [7:0]  year_alarm_en_ff;
    logic [7:0]  ctrl_ff;
    logic [7:0]  ctrl_pend_ff;
    logic        ctrl_pend_valid_ff;
    logic [7:0]  cc_ff;
    logic        mode_pend_ff;
    logic        start_pend_ff;
    logic        swrst_pend_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic [8:0]  div_ff;
    logic        match_prev_ff;
    logic        alarm_flag_ff;
    logic        periodic_flag_ff;
    logic        carry_flag_ff;
    logic        clk_out_ff;

    logic        req;
    logic        wr_take;
    logic        wr_lane0;
    logic        cal_match;
    logic        bin_match;
    logic        match_now;
    logic [31:0] bin_alarm_value;
    logic [31:0] bin_mask;
    logic [8:0]  nxt_div;
    logic [9:0]  pmask;
    logic        periodic_hit;
    logic [31:0] nxt_rdata;

    // ==========================================================
    // Avalon slave: one wait cycle, then the answer
    // ==========================================================
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_ff;
    assign wr_take         = avs_write & ack_ff;
    assign wr_lane0        = wr_take & avs_byteenable[0];
    assign avs_readdata    = rdata_ff;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;
    end

    always_comb
    begin
        nxt_rdata = 32'h00000000;
        if (hit(avs_address, IDX_WEEKDAY_ALARM))
            nxt_rdata = {24'h000000, weekday_alarm_ff};
        else if (hit(avs_address, IDX_DATE_ALARM))
            nxt_rdata = {24'h000000, date_alarm_ff};
        else if (hit(avs_address, IDX_MONTH_ALARM))
            nxt_rdata = {24'h000000, month_alarm_ff};
        else if (hit(avs_address, IDX_YEAR_ALARM))
            nxt_rdata = {24'h000000, year_alarm_ff};
        else if (hit(avs_address, IDX_YEAR_ALARM_EN))
            nxt_rdata = {24'h000000, year_alarm_en_ff};
        else if (hit(avs_address, IDX_IRQ_OUT_CTRL))
            nxt_rdata = {24'h000000, ctrl_ff};
        else if (hit(avs_address, IDX_COUNT_CTRL))
            nxt_rdata = {24'h000000, cc_ff};
        else
            nxt_rdata = 32'h00000000;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            rdata_ff <= 32'h00000000;
        else if (avs_read & ~ack_ff)
            rdata_ff <= nxt_rdata;
    end

    // ==========================================================
    // Alarm registers
    // ==========================================================
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            weekday_alarm_ff <= ALARM_RST;
            date_alarm_ff    <= ALARM_RST;
            month_alarm_ff   <= ALARM_RST;
            year_alarm_ff    <= ALARM_RST;
            year_alarm_en_ff <= ALARM_RST;
        end
        else if (swrst_pend_ff & count_tick)
        begin
            weekday_alarm_ff <= ALARM_RST;
            date_alarm_ff    <= ALARM_RST;
            month_alarm_ff   <= ALARM_RST;
            year_alarm_ff    <= ALARM_RST;
            year_alarm_en_ff <= ALARM_RST;
        end
        else if (wr_lane0)
        begin
            // Calendar weekday code 7 is refused as a whole write
            if (hit(avs_address, IDX_WEEKDAY_ALARM) &&
                !(!cc_ff[CC_MODE_BIT] && avs_writedata[2:0] == WEEKDAY_BANNED))
                weekday_alarm_ff <= avs_writedata[7:0];
            if (hit(avs_address, IDX_DATE_ALARM))
                date_alarm_ff <= avs_writedata[7:0];
            if (hit(avs_address, IDX_MONTH_ALARM))
                month_alarm_ff <= avs_writedata[7:0];
            if (hit(avs_address, IDX_YEAR_ALARM))
                year_alarm_ff <= avs_writedata[7:0];
            if (hit(avs_address, IDX_YEAR_ALARM_EN))
                year_alarm_en_ff <= avs_writedata[7:0];
        end
    end

    // ==========================================================
    // Count control: start, software reset, output enable, mode
    // ==========================================================
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            cc_ff         <= CTRL_RST;
            mode_pend_ff  <= 1'b0;
            start_pend_ff <= 1'b0;
            swrst_pend_ff <= 1'b0;
        end
        else
        begin
            if (wr_lane0 && hit(avs_address, IDX_COUNT_CTRL))
            begin
                cc_ff[CC_OUT_EN_BIT] <= avs_writedata[CC_OUT_EN_BIT];
                mode_pend_ff         <= avs_writedata[CC_MODE_BIT];
                start_pend_ff        <= avs_writedata[CC_START_BIT];
                if (avs_writedata[CC_SWRST_BIT])
                begin
                    swrst_pend_ff       <= 1'b1;
                    cc_ff[CC_SWRST_BIT] <= 1'b1;
                end
            end
            else if (count_tick)
            begin
                // Mode and start are taken on every count tick with no count control write, the same tick that completes a pending software reset
                cc_ff[CC_MODE_BIT]  <= mode_pend_ff;
                cc_ff[CC_START_BIT] <= start_pend_ff;
                if (swrst_pend_ff)
                begin
                    swrst_pend_ff        <= 1'b0;
                    cc_ff[CC_SWRST_BIT]  <= 1'b0;
                    cc_ff[CC_OUT_EN_BIT] <= 1'b0;
                end
            end
        end
    end

    assign count_run         = cc_ff[CC_START_BIT];
    assign count_mode_select = cc_ff[CC_MODE_BIT];

    // ==========================================================
    // Interrupt and output control; AIE, PIE and PES staged onto the count source, CIE and rate select written at once
    // ==========================================================
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ctrl_ff            <= CTRL_RST;
            ctrl_pend_ff       <= CTRL_RST;
            ctrl_pend_valid_ff <= 1'b0;
        end
        else if (wr_lane0 && hit(avs_address, IDX_IRQ_OUT_CTRL))
        begin
            ctrl_pend_ff         <= avs_writedata[7:0];
            ctrl_pend_valid_ff   <= 1'b1;
            ctrl_ff[CIE_BIT]     <= avs_writedata[CIE_BIT];
            // Only safe while stopped and the output is off; not policed here
            ctrl_ff[RATE_SEL_BIT] <= avs_writedata[RATE_SEL_BIT];
        end
        else if (count_tick && ctrl_pend_valid_ff)
        begin
            ctrl_ff[AIE_BIT]     <= ctrl_pend_ff[AIE_BIT];
            ctrl_ff[PIE_BIT]     <= ctrl_pend_ff[PIE_BIT];
            ctrl_ff[7:PES_LSB]   <= ctrl_pend_ff[7:PES_LSB];
            ctrl_pend_valid_ff   <= 1'b0;
        end
    end

    // ==========================================================
    // Alarm compare
    // ==========================================================
    assign cal_match = (!weekday_alarm_ff[CMP_EN_BIT] || weekday_alarm_ff[2:0] == weekday_counter) &&
                       (!date_alarm_ff[CMP_EN_BIT]    || date_alarm_ff[5:0] == date_counter) &&
                       (!month_alarm_ff[CMP_EN_BIT]   || month_alarm_ff[4:0] == month_counter) &&
                       (!year_alarm_en_ff[CMP_EN_BIT] || year_alarm_ff == year_counter);
    assign bin_alarm_value = {weekday_alarm_ff, bin_alarm_low};
    assign bin_mask        = {year_alarm_en_ff, year_alarm_ff, month_alarm_ff, date_alarm_ff};
    assign bin_match       = ((binary_counter_value ^ bin_alarm_value) & bin_mask) == 32'h00000000;
    assign match_now       = cc_ff[CC_MODE_BIT] ? bin_match : cal_match;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            match_prev_ff <= 1'b0;
        else if (count_tick)
            match_prev_ff <= match_now;
    end

    // Set beats acknowledge in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            alarm_flag_ff <= 1'b0;
        else if (count_tick && match_now && !match_prev_ff && !swrst_pend_ff)
            alarm_flag_ff <= 1'b1;
        else if (alarm_ack)
            alarm_flag_ff <= 1'b0;
    end

    // ==========================================================
    // Periodic divider and clock output
    // ==========================================================
    assign nxt_div      = div_ff + 9'h001;
    assign pmask        = pes_mask(ctrl_ff[7:PES_LSB]);
    assign periodic_hit = tick_256hz && pmask[9] && ((nxt_div & pmask[8:0]) == 9'h000);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            div_ff <= DIV_RST;
        else if (swrst_pend_ff & count_tick)
            div_ff <= DIV_RST;
        else if (tick_256hz)
            div_ff <= nxt_div;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            periodic_flag_ff <= 1'b0;
        else if (periodic_hit)
            periodic_flag_ff <= 1'b1;
        else if (periodic_ack)
            periodic_flag_ff <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            carry_flag_ff <= 1'b0;
        else if (carry_event)
            carry_flag_ff <= 1'b1;
        else if (carry_ack)
            carry_flag_ff <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            clk_out_ff <= 1'b0;
        else
            clk_out_ff <= cc_ff[CC_OUT_EN_BIT] &
                          (ctrl_ff[RATE_SEL_BIT] ? div_ff[OUT_64HZ_BIT] : div_ff[OUT_1HZ_BIT]);
    end

    assign clock_out_pin = clk_out_ff;
    assign alarm_irq     = alarm_flag_ff & ctrl_ff[AIE_BIT];
    assign carry_irq     = carry_flag_ff & ctrl_ff[CIE_BIT];
    assign periodic_irq  = periodic_flag_ff & ctrl_ff[PIE_BIT];

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence s_swrst_done;
        swrst_pend_ff && count_tick;
    endsequence

    sequence s_cleared;
        weekday_alarm_ff == 8'h00 && date_alarm_ff == 8'h00 && year_alarm_en_ff == 8'h00;
    endsequence

    AST_SWRST_CLEARS: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_swrst_done |=> s_cleared)
        else $error("software reset left an alarm register set");

    AST_SWRST_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_swrst_done |=> !cc_ff[CC_SWRST_BIT])
        else $error("software reset bit did not clear");

    AST_NO_WEEKDAY7: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!cc_ff[CC_MODE_BIT] && $changed(weekday_alarm_ff) && !$past(swrst_pend_ff))
        |-> weekday_alarm_ff[2:0] != WEEKDAY_BANNED)
        else $error("weekday code 7 accepted");

    AST_CAL_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
        (count_tick && !cc_ff[CC_MODE_BIT] && cal_match && !match_prev_ff && !swrst_pend_ff)
        |=> alarm_flag_ff)
        else $error("calendar match did not set alarm flag");

    AST_BIN_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
        (count_tick && cc_ff[CC_MODE_BIT] && bin_match && !match_prev_ff && !swrst_pend_ff)
        |=> alarm_flag_ff)
        else $error("binary match did not set alarm flag");

    AST_ALARM_GATE: assert property (@(posedge sys_clk) disable iff (!resetn)
        alarm_irq |-> alarm_flag_ff && ctrl_ff[AIE_BIT])
        else $error("alarm request without enable");

    AST_PERIODIC_GATE: assert property (@(posedge sys_clk) disable iff (!resetn)
        (periodic_hit && ctrl_ff[PIE_BIT]) |=> periodic_irq)
        else $error("periodic event not requested");

    AST_CARRY_GATE: assert property (@(posedge sys_clk) disable iff (!resetn)
        (carry_event && ctrl_ff[CIE_BIT] && !(wr_lane0 && hit(avs_address, IDX_IRQ_OUT_CTRL))) |=> carry_irq)
        else $error("carry event not requested");

    AST_CTRL_SYNC: assert property (@(posedge sys_clk) disable iff (!resetn)
        $changed(ctrl_ff[AIE_BIT]) |-> $past(count_tick))
        else $error("alarm enable changed off the count source");

    AST_PES_UNDEF: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ctrl_ff[7:PES_LSB] < 4'b0110) |-> !periodic_hit)
        else $error("periodic event on undefined select");

    AST_YEAR_UPPER: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ack_ff && avs_read && hit(avs_address, IDX_YEAR_ALARM)) |-> avs_readdata[15:8] == 8'h00)
        else $error("year alarm upper byte not zero");

endmodule : rtcacp_top

// [verif/rtcacp_top_test.sv]
// Self-checking bench for the alarm compare and interrupt control block.
// Assumes the bench plays bus master, counters, prescaler ticks and interrupt controller.
`timescale 1ns/1ns
module rtcacp_top_test;
    import rtcacp_pkg::*;

    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, avs_readdata;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [5:0]  pl = 6'h00;
    logic        count_tick, tick_256hz, carry_event;
    logic [2:0]  weekday_counter = 3'h0;
    logic [5:0]  date_counter = 6'h0;
    logic [4:0]  month_counter = 5'h0;
    logic [7:0]  year_counter = 8'h0;
    logic [31:0] binary_counter_value = 32'h0;
    logic [23:0] bin_alarm_low = 24'h0;
    logic        alarm_ack, periodic_ack, carry_ack;
    localparam int TK = 0, T256 = 1, CEV = 2, AACK = 3, PACK = 4, CACK = 5;
    assign {carry_ack, periodic_ack, alarm_ack, carry_event, tick_256hz, count_tick} = pl;
    logic        alarm_irq, periodic_irq, carry_irq, clock_out_pin, count_run, count_mode_select;
    int          n_fail = 0, tests_run = 0, cyc = 0;

    rtcacp_top dut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .count_tick, .tick_256hz, .carry_event,
        .weekday_counter, .date_counter, .month_counter, .year_counter, .binary_counter_value,
        .bin_alarm_low, .alarm_ack, .periodic_ack, .carry_ack, .alarm_irq, .periodic_irq,
        .carry_irq, .clock_out_pin, .count_run, .count_mode_select);

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [31:0] idx, input logic [7:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= idx << 2;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [31:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rdc(input logic [31:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h0, q);
        cmp(q, {24'h0, e});
    endtask : rdc

    // One-cycle pulse on line k, then settle time; ends on a rising edge
    task automatic pulse(input int k);
        @(posedge sys_clk);
        pl <= 6'h01 << k;
        @(posedge sys_clk);
        pl <= 6'h00;
        repeat (2) @(posedge sys_clk);
    endtask : pulse

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs();
        rdc(IDX_WEEKDAY_ALARM, ALARM_RST);
        rdc(IDX_IRQ_OUT_CTRL, CTRL_RST);
        rdc(32'h0008c420, 8'h00);
        wr(IDX_WEEKDAY_ALARM, 8'h7d);
        rdc(IDX_WEEKDAY_ALARM, 8'h7d);
        wr(IDX_WEEKDAY_ALARM, 8'h07);
        rdc(IDX_WEEKDAY_ALARM, 8'h7d);
        wr(IDX_DATE_ALARM, 8'h71);
        rdc(IDX_DATE_ALARM, 8'h71);
        wr(IDX_MONTH_ALARM, 8'h72);
        rdc(IDX_MONTH_ALARM, 8'h72);
        wr(IDX_YEAR_ALARM, 8'h99);
        rdc(IDX_YEAR_ALARM, 8'h99);
        wr(IDX_YEAR_ALARM_EN, 8'h7f);
        rdc(IDX_YEAR_ALARM_EN, 8'h7f);
        $display("register test done");
    endtask : t_regs

    task automatic t_cal();
        wr(IDX_WEEKDAY_ALARM, 8'h83);
        wr(IDX_YEAR_ALARM_EN, 8'h00);
        weekday_counter <= 3'h2;
        pulse(TK);
        weekday_counter <= 3'h3;
        pulse(TK);
        cmp(alarm_irq, 1'b0);
        wr(IDX_IRQ_OUT_CTRL, 8'h01);
        rdc(IDX_IRQ_OUT_CTRL, 8'h00);
        pulse(TK);
        cmp(alarm_irq, 1'b1);
        pulse(AACK);
        cmp(alarm_irq, 1'b0);
        // Enabled year field now mismatches, disabled date field is ignored
        wr(IDX_YEAR_ALARM_EN, 8'h80);
        year_counter <= 8'h98;
        pulse(TK);
        cmp(alarm_irq, 1'b0);
        year_counter <= 8'h99;
        pulse(TK);
        cmp(alarm_irq, 1'b1);
        pulse(AACK);
        $display("calendar alarm test done");
    endtask : t_cal

    task automatic t_bin();
        wr(IDX_COUNT_CTRL, 8'h80);
        pulse(TK);
        cmp(count_mode_select, 1'b1);
        wr(IDX_WEEKDAY_ALARM, 8'h07);
        rdc(IDX_WEEKDAY_ALARM, 8'h07);
        wr(IDX_DATE_ALARM, 8'hff);
        wr(IDX_MONTH_ALARM, 8'h00);
        wr(IDX_YEAR_ALARM, 8'h00);
        wr(IDX_YEAR_ALARM_EN, 8'hff);
        bin_alarm_low <= 24'h00005a;
        binary_counter_value <= 32'h0712345b;
        pulse(TK);
        cmp(alarm_irq, 1'b0);
        binary_counter_value <= 32'h07abcd5a;
        pulse(TK);
        cmp(alarm_irq, 1'b1);
        pulse(AACK);
        $display("binary alarm test done");
    endtask : t_bin

    task automatic t_per();
        int n;
        wr(IDX_IRQ_OUT_CTRL, 8'h60);
        pulse(TK);
        pulse(T256);
        cmp(periodic_irq, 1'b0);
        for (int c = 6; c < 16; c++)
        begin
            wr(IDX_IRQ_OUT_CTRL, {c[3:0], 4'h4});
            pulse(TK);
            n = 0;
            while (periodic_irq !== 1'b1 && n < 600)
            begin
                pulse(T256);
                n++;
            end
            pulse(PACK);
            n = 0;
            do
            begin
                pulse(T256);
                n++;
            end while (periodic_irq !== 1'b1 && n < 600);
            cmp(n, 32'h1 << (c - 6));
            pulse(PACK);
        end
        wr(IDX_IRQ_OUT_CTRL, 8'h04);
        pulse(TK);
        repeat (4) pulse(T256);
        cmp(periodic_irq, 1'b0);
        $display("periodic test done");
    endtask : t_per

    task automatic t_carry_out();
        logic p;
        wr(IDX_IRQ_OUT_CTRL, 8'h0a);
        pulse(CEV);
        cmp(carry_irq, 1'b1);
        pulse(CACK);
        cmp(carry_irq, 1'b0);
        wr(IDX_COUNT_CTRL, 8'h88);
        repeat (2) pulse(T256);
        p = clock_out_pin;
        repeat (2) pulse(T256);
        cmp(clock_out_pin, !p);
        // Rate moved only with counting stopped and the output off
        wr(IDX_COUNT_CTRL, 8'h80);
        wr(IDX_IRQ_OUT_CTRL, 8'h02);
        wr(IDX_COUNT_CTRL, 8'h88);
        pulse(T256);
        p = clock_out_pin;
        repeat (128) pulse(T256);
        cmp(clock_out_pin, !p);
        $display("carry and clock out test done");
    endtask : t_carry_out

    task automatic t_swrst();
        logic [31:0] ids [5] = '{IDX_WEEKDAY_ALARM, IDX_DATE_ALARM, IDX_MONTH_ALARM,
                                 IDX_YEAR_ALARM, IDX_YEAR_ALARM_EN};
        wr(IDX_COUNT_CTRL, 8'h82);
        rdc(IDX_COUNT_CTRL, 8'h82);
        pulse(TK);
        rdc(IDX_COUNT_CTRL, 8'h80);
        for (int i = 0; i < 5; i++)
            rdc(ids[i], ALARM_RST);
        wr(IDX_COUNT_CTRL, 8'h81);
        cmp(count_run, 1'b0);
        pulse(TK);
        cmp(count_run, 1'b1);
        $display("software reset test done");
    endtask : t_swrst

    // ==========================================================
    // Verdict and watchdog
    // ==========================================================
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // Periodic sweep and 1 Hz output dominate run time, about 7k cycles
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs();
        t_cal();
        t_bin();
        t_per();
        t_carry_out();
        t_swrst();
        report_and_stop();
    end

endmodule : rtcacp_top_test
